// >>> clock_source_startup_select.v
`timescale 1ns/10ps
`include "clock_source_startup_select_map.vh"
module clock_source_startup_select
#(
  parameter        [2:0]  XTAL_UPPER = `SEL_XTAL_UPPER,
  parameter        [31:0] CYC_MS     = `CYC_PER_MS
)
(
  input  wire       clk,
  input  wire       rst_n,
  input  wire       fuse_valid,
  input  wire [3:0] clock_source_select,
  input  wire [1:0] startup_time_setting,
  input  wire       divide_by_eight_setting,
  input  wire [7:0] factory_calibration,
  input  wire       trim_write,
  input  wire [7:0] trim_data,
  input  wire       wake_request,
  input  wire       xtal_tick,
  input  wire       rc_tick,
  input  wire       lf128_tick,
  input  wire       watchdog_tick,
  output reg  [1:0] system_source,
  output reg        use_divide_by_eight,
  output reg  [7:0] rc_trim_register,
  output reg        core_clock_enable,
  output reg        setting_reserved,
  output reg        watchdog_clock_tick
);
  // ==========================================================
  // Setting decode
  // ==========================================================
  localparam [1:0] st_idle  = 2'h0;
  localparam [1:0] st_start = 2'h1;
  localparam [1:0] st_wait  = 2'h2;
  localparam [1:0] st_run   = 2'h3;

  function [1:0] decode_source;
    input [3:0] sel;
    begin
      if (sel == `SEL_RC)
        decode_source = `SRC_RC;
      else if (sel == `SEL_LF128)
        decode_source = `SRC_LF128;
      else if (sel[3:1] == XTAL_UPPER)
        decode_source = `SRC_XTAL;
      else
        decode_source = `SRC_NONE;
    end
  endfunction

  // Code 11 of the start-up setting and unknown sources leave the core stopped
  function setting_is_reserved;
    input [1:0] code;
    input [1:0] source;
    begin
      if (code == 2'h3)
        setting_is_reserved = 1'b1;
      else if (source == `SRC_NONE)
        setting_is_reserved = 1'b1;
      else
        setting_is_reserved = 1'b0;
    end
  endfunction

  reg [1:0]  state;
  reg [1:0]  next_state;
  reg        from_reset;
  reg        cnt_start;
  reg [3:0]  sel_r;
  reg [1:0]  sut_r;
  reg        div8_r;
  reg        loaded;
  reg [15:0] next_ticks;
  reg [31:0] next_ref;
  reg        next_tick;
  wire       wait_done;
  wire [1:0] src = decode_source(sel_r);
  wire       reserved = setting_is_reserved(sut_r, src);

  // ==========================================================
  // Fuse capture
  // ==========================================================
  // Until the fuse store answers, the delivered defaults stand
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sel_r  <= `DEFAULT_SEL;
      sut_r  <= `DEFAULT_SUT;
      div8_r <= `DEFAULT_DIV8;
      loaded <= 1'b0;
    end
    else if (!loaded && fuse_valid)
    begin
      sel_r  <= clock_source_select;
      sut_r  <= startup_time_setting;
      div8_r <= divide_by_eight_setting;
      loaded <= 1'b1;
    end
  end

  // ==========================================================
  // Trim register
  // ==========================================================
  // The factory byte goes in with the fuses; a write in that same cycle is
  // dropped, later writes overwrite the byte
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rc_trim_register <= 8'h00;
    else if (!loaded && fuse_valid)
      rc_trim_register <= factory_calibration;
    else if (loaded && trim_write)
      rc_trim_register <= trim_data;
  end

  // ==========================================================
  // Wait selection
  // ==========================================================
  // Wake wait, counted in ticks of the chosen oscillator
  function [15:0] wake_ticks;
    input [1:0] source;
    input       low_bit;
    begin
      if (source == `SRC_XTAL)
      begin
        if (low_bit)
          wake_ticks = `WAKE_XTAL1;
        else
          wake_ticks = `WAKE_XTAL0;
      end
      else
        wake_ticks = `WAKE_SHORT;
    end
  endfunction

  // Extra reset time-out, counted in reference-clock cycles
  function [31:0] reset_ref_cycles;
    input [1:0]  code;
    input [31:0] per_ms;
    begin
      if (code == 2'h1)
        reset_ref_cycles = `DELAY_SHORT_MS * per_ms;
      else if (code == 2'h2)
        reset_ref_cycles = `DELAY_LONG_MS * per_ms;
      else
        reset_ref_cycles = 32'h00000000;
    end
  endfunction

  // Only the chosen oscillator's ticks reach the counter
  wire [3:0] src_onehot = 4'h1 << src;
  wire [2:0] osc_ticks  = {lf128_tick, rc_tick, xtal_tick};
  wire [2:0] tick_hit;

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : tick_sel
      assign tick_hit[g] = osc_ticks[g] && src_onehot[g + 1];
    end
  endgenerate

  always @*
  begin
    next_tick  = |tick_hit;
    next_ticks = wake_ticks(src, sel_r[0]);
    next_ref   = 32'h00000000;
    if (from_reset)
    begin
      next_ticks = `RESET_CYCLES;
      next_ref   = reset_ref_cycles(sut_r, CYC_MS);
    end
  end

  // ==========================================================
  // Start-up sequencer
  // ==========================================================
  always @*
  begin
    next_state = state;
    case (state)
      st_idle:
      begin
        if (loaded && !reserved)
          next_state = st_start;
      end
      st_start:
      begin
        next_state = st_wait;
      end
      st_wait:
      begin
        if (wait_done)
          next_state = st_run;
      end
      st_run:
      begin
        if (wake_request)
          next_state = st_start;
      end
      default:
      begin
        next_state = st_idle;
      end
    endcase
  end

  // The counter is restarted on the same edge that enters the wait state, so that its
  // done flag from the previous wait is cleared before the wait is judged
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state      <= st_idle;
      from_reset <= 1'b1;
      cnt_start  <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      cnt_start <= (next_state == st_start);
      if (state == st_wait && wait_done)
        from_reset <= 1'b0;
    end
  end

  // ==========================================================
  // Core clock gate
  // ==========================================================
  // A wake request drops the core clock until the new wait is over
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      core_clock_enable <= 1'b0;
    end
    else if (state == st_wait && wait_done)
    begin
      core_clock_enable <= 1'b1;
    end
    else if (next_state == st_start)
    begin
      core_clock_enable <= 1'b0;
    end
  end

  // ==========================================================
  // Status outputs
  // ==========================================================
  // Source reads as none until the fuses are in; the divide flag shows its default before that
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      system_source       <= `SRC_NONE;
      use_divide_by_eight <= 1'b0;
      setting_reserved    <= 1'b0;
    end
    else if (loaded)
    begin
      system_source       <= src;
      use_divide_by_eight <= div8_r;
      setting_reserved    <= reserved;
    end
    else
    begin
      system_source       <= `SRC_NONE;
      use_divide_by_eight <= div8_r;
      setting_reserved    <= 1'b0;
    end
  end

  // ==========================================================
  // Watchdog clock
  // ==========================================================
  // Watchdog stays on its own oscillator; reset time-out counts the chosen oscillator and clk
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      watchdog_clock_tick <= 1'b0;
    end
    else
    begin
      watchdog_clock_tick <= watchdog_tick;
    end
  end

  // ==========================================================
  // Start-up counter
  // ==========================================================
  startup_counter u_startup_counter
  (
    .clk         (clk),
    .rst_n       (rst_n),
    .start       (cnt_start),
    .osc_tick    (next_tick),
    .tick_target (next_ticks),
    .ref_target  (next_ref),
    .done        (wait_done)
  );
endmodule

// >>> clock_source_startup_select_assertions.sv
`timescale 1ns/10ps
module startup_select_checker
#(
  parameter [31:0] CYC_MS = 32'd20
)
(
  input wire       clk,
  input wire       rst_n,
  input wire [3:0] clock_source_select,
  input wire [1:0] startup_time_setting,
  input wire       divide_by_eight_setting,
  input wire [7:0] factory_calibration,
  input wire       trim_write,
  input wire [7:0] trim_data,
  input wire       wake_request,
  input wire       watchdog_tick,
  input wire [1:0] system_source,
  input wire       use_divide_by_eight,
  input wire [7:0] rc_trim_register,
  input wire       core_clock_enable,
  input wire       setting_reserved,
  input wire       watchdog_clock_tick
);
  reg  [15:0] off_cnt;
  reg         woke;
  wire [31:0] wake_lo = system_source == 2'h1 ? (clock_source_select[0] ? 32767 : 1023) :
                        system_source == 2'h3 ? 11 : 5;
  wire [31:0] rst_lo  = startup_time_setting == 2'h2 ? 65 * CYC_MS :
                        startup_time_setting == 2'h1 ? 4 * CYC_MS : 14;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ====
  // Cycles with the core clock off, and whether a wake caused it
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      off_cnt <= 16'h0000;
      woke    <= 1'b0;
    end
    else
    begin
      off_cnt <= core_clock_enable ? 16'h0000 : off_cnt + 16'h0001;
      woke    <= (wake_request && core_clock_enable) || (woke && !core_clock_enable);
    end
  wd_pass_a: assert property ($past(rst_n) |-> watchdog_clock_tick == $past(watchdog_tick))
    else $error("watchdog tick not passed on");
  src_decode_a: assert property (core_clock_enable |-> system_source ==
    (clock_source_select == 4'h2 ? 2'h2 : clock_source_select == 4'h3 ? 2'h3 : 2'h1))
    else $error("wrong source");
  div_follow_a: assert property (system_source != 2'h0 |->
    use_divide_by_eight == divide_by_eight_setting) else $error("divide flag wrong");
  trim_load_a: assert property ($past(system_source) == 2'h0 && system_source != 2'h0 |->
    rc_trim_register == factory_calibration) else $error("trim not loaded");
  trim_write_a: assert property (trim_write && system_source != 2'h0 |=>
    rc_trim_register == $past(trim_data)) else $error("trim write lost");
  reserved_idle_a: assert property (startup_time_setting == 2'h3 || setting_reserved |->
    !core_clock_enable) else $error("reserved code ran");
  wake_drop_a: assert property (wake_request && core_clock_enable |-> ##[1:3]
    !core_clock_enable) else $error("wake kept clock");
  wake_wait_a: assert property ($rose(core_clock_enable) && woke |->
    off_cnt >= wake_lo && off_cnt <= wake_lo + 40) else $error("wake wait wrong");
  reset_wait_a: assert property ($rose(core_clock_enable) && !woke |->
    off_cnt >= rst_lo && off_cnt <= rst_lo + 40) else $error("reset delay wrong");
endmodule

// >>> clock_source_startup_select_map.vh
`ifndef CLOCK_SOURCE_STARTUP_SELECT_MAP_VH
`define CLOCK_SOURCE_STARTUP_SELECT_MAP_VH
`define SEL_RC          4'h2
`define SEL_LF128       4'h3
`define SEL_XTAL_UPPER  3'h3
`define DEFAULT_SEL     4'h2
`define DEFAULT_SUT     2'h2
`define DEFAULT_DIV8    1'b1
`define SRC_NONE        2'h0
`define SRC_XTAL        2'h1
`define SRC_RC          2'h2
`define SRC_LF128       2'h3
`define WAKE_SHORT      16'h0006
`define WAKE_XTAL0      16'h0400
`define WAKE_XTAL1      16'h8000
`define RESET_CYCLES    16'h000E
`define CLK_HZ          10000000
`define DELAY_SHORT_MS  4
`define DELAY_LONG_MS   65
`define CYC_PER_MS      (`CLK_HZ / 1000)
`endif

// >>> clock_source_startup_select_tb.sv
`timescale 1ns/10ps
module clock_source_startup_select_tb;
  // Entries are {select, start-up code, divide}
  localparam [48:0] CFG = {7'h1E, 7'h17, 7'h12, 7'h38, 7'h33, 7'h18, 7'h15};
  reg        clk, rst_n, divide_by_eight_setting, trim_write, wake_request, watchdog_tick;
  reg  [3:0] clock_source_select;
  reg  [1:0] startup_time_setting;
  reg  [7:0] factory_calibration, trim_data;
  wire       fuse_valid, xtal_tick, rc_tick, lf128_tick, use_divide_by_eight;
  wire       core_clock_enable, setting_reserved, watchdog_clock_tick;
  wire [1:0] system_source;
  wire [7:0] rc_trim_register;
  integer    err_count, checks, i, n, wake_min;
  always #50 clk = !clk;
  always @(posedge clk) #1 watchdog_tick = 1'($urandom & 1);
  osc_fuse_model partner (.clk, .rst_n, .fuse_valid, .xtal_tick, .rc_tick, .lf128_tick);
  clock_source_startup_select #(.CYC_MS(20)) dut (.clk, .rst_n, .fuse_valid,
    .clock_source_select, .startup_time_setting, .divide_by_eight_setting,
    .factory_calibration, .trim_write, .trim_data, .wake_request, .xtal_tick, .rc_tick,
    .lf128_tick, .watchdog_tick, .system_source, .use_divide_by_eight, .rc_trim_register,
    .core_clock_enable, .setting_reserved, .watchdog_clock_tick);
  // ====
  // Checking and waiting
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp)
      begin
        err_count = err_count + 1;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wait_en(input v);
    begin
      n = 0;
      while (core_clock_enable !== v && n < 40000)
      begin
        @(posedge clk);
        #1 n = n + 1;
      end
      chk(core_clock_enable, v);
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial
  begin
    #6000000 err_count = err_count + 1;
    give_verdict;
  end
  initial
  begin
    {clk, rst_n, trim_write, wake_request, watchdog_tick, trim_data} = 0;
    {err_count, checks} = 0;
    n = $urandom(81464);
    for (i = 0; i < 7; i = i + 1)
    begin
      rst_n = 0;
      {clock_source_select, startup_time_setting, divide_by_eight_setting} = CFG[i*7 +: 7];
      factory_calibration = 8'($urandom);
      repeat (4) @(posedge clk);
      #1 rst_n = 1;
      if (startup_time_setting == 2'h3)
      begin
        repeat (60) @(posedge clk);
        #1 chk(setting_reserved, 1);
        chk(core_clock_enable, 0);
      end
      else
      begin
        wait_en(1);
        chk(system_source, clock_source_select == 4'h2 ? 2 : clock_source_select == 4'h3 ? 3 : 1);
        chk(use_divide_by_eight, divide_by_eight_setting);
        chk(rc_trim_register, factory_calibration);
        trim_data = 8'($urandom);
        trim_write = 1;
        @(posedge clk);
        #1 trim_write = 0;
        @(posedge clk);
        #1 chk(rc_trim_register, trim_data);
        wake_request = 1;
        @(posedge clk);
        #1 wake_request = 0;
        wait_en(0);
        wait_en(1);
        wake_min = clock_source_select[3:1] != 3'h3 ? 6 : clock_source_select[0] ? 32768 : 1024;
        chk(n >= wake_min, 1);
        repeat (2) @(posedge clk);
        #1;
      end
    end
    give_verdict;
  end
endmodule
bind clock_source_startup_select startup_select_checker #(.CYC_MS(CYC_MS)) checker_i (.clk,
  .rst_n, .clock_source_select, .startup_time_setting, .divide_by_eight_setting,
  .factory_calibration, .trim_write, .trim_data, .wake_request, .watchdog_tick,
  .system_source, .use_divide_by_eight, .rc_trim_register, .core_clock_enable,
  .setting_reserved, .watchdog_clock_tick);

// >>> osc_fuse_model.sv
`timescale 1ns/10ps
// ====
// Fuse store and oscillator ticks
module osc_fuse_model
(
  input  wire clk,
  input  wire rst_n,
  output reg  fuse_valid,
  output reg  xtal_tick,
  output reg  rc_tick,
  output reg  lf128_tick
);
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      fuse_valid <= 1'b0;
      xtal_tick  <= 1'b0;
      rc_tick    <= 1'b0;
      lf128_tick <= 1'b0;
    end
    else
    begin
      fuse_valid <= 1'b1;
      xtal_tick  <= 1'b1;
      rc_tick    <= 1'b1;
      lf128_tick <= !lf128_tick;
    end
endmodule

// >>> startup_counter.v
`timescale 1ns/10ps
// Counts selected-oscillator ticks and reference-clock cycles; done when both expire
module startup_counter
(
  input  wire        clk,
  input  wire        rst_n,
  input  wire        start,
  input  wire        osc_tick,
  input  wire [15:0] tick_target,
  input  wire [31:0] ref_target,
  output reg         done
);
  reg [15:0] tick_count;
  reg [31:0] ref_count;
  reg        busy;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_count <= 16'h0000;
      ref_count  <= 32'h00000000;
      busy       <= 1'b0;
      done       <= 1'b0;
    end
    else if (start)
    begin
      tick_count <= 16'h0000;
      ref_count  <= 32'h00000000;
      busy       <= 1'b1;
      done       <= 1'b0;
    end
    else if (busy)
    begin
      if (osc_tick && tick_count != tick_target)
        tick_count <= tick_count + 16'h0001;
      if (ref_count != ref_target)
        ref_count <= ref_count + 32'h00000001;
      if (tick_count == tick_target && ref_count == ref_target)
      begin
        busy <= 1'b0;
        done <= 1'b1;
      end
    end
  end
endmodule
